// File: src/apf_gpio.sv
// Behaviour
// - Three receive pins act as flags only while shared timing is set.
// - Bit clock flag direction follows its direction bit: one out, zero in.
// - Frame sync flag only without buffer-enable use; direction from its bit.
// - Fast clock flag direction follows its direction bit: one out, zero in.
// - Input flags latch at the first receive bit and hold until the next.
// - Latched input flags move to status bits when the receive word lands.
// - Output flags drive pins from control bits when transmit data loads.
// - Per pin, direction and control bits select off, input, output, serial.
// - Hardware and software reset clear pin select and pin direction.
// - A general input pin reads back its present level.
// - A general output pin drives its written data bit.
// - A disconnected pin's data bit is cleared by hardware reset but kept through software reset.
// - Select and direction both zero hold both sections in reset.
// - Each section reset bit resets only its own section.
// - Internal clocks and frame sync run once the port is enabled.
// - Receive only with a channel enabled and after a frame sync.
// - An enabled transmitter stays tri-stated until the next frame sync.
// - Configure with enables clear while in reset; no interrupts meanwhile.
// - Each pin swaps with the sibling port's same pin under its own bit.
// - Under shared timing the transmitter supplies clocks and frame sync.
module apf_gpio
  import apf_pkg::*;
(
  // Clock and reset.
  input  wire logic                  clk,
  input  wire logic                  arst_n,
  input  wire logic                  soft_rst,
  // AXI4-Lite write channels.
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready,
  // Serial core events and status.
  input  wire logic                  rx_first_bit,
  input  wire logic                  rx_word_done,
  input  wire logic                  tx_word_load,
  input  wire logic                  tx_frame_sync,
  input  wire logic                  rx_frame_sync,
  input  wire logic                  tx_empty_flag,
  input  wire apf_pkg::apf_drive_type ser_drive,
  // Section control toward the serial core.
  output logic                       tx_rst,
  output logic                       rx_rst,
  output logic                       clkgen_run,
  output logic                       rx_capture_en,
  output logic [5:0]                 tx_drive_en,
  output logic                       irq_allow,
  output logic [11:0]                ser_in_level,
  // Own pads.
  input  wire logic [11:0]           pad_in,
  output apf_pkg::apf_drive_type     pad_drive,
  // Sibling port pairing.
  input  wire logic [11:0]           pin_swap,
  input  wire logic [11:0]           sib_pad_in,
  input  wire apf_pkg::apf_drive_type sib_drive,
  output apf_pkg::apf_drive_type     sib_pad_drive,
  output logic [11:0]                sib_in_level
);
  import apf_pkg::*;

  // Software-visible control state.
  logic [11:0]   pin_sel_reg;
  logic [11:0]   pin_dir_reg;
  logic [11:0]   pin_lvl_reg;
  logic [7:0]    common_reg;
  logic [7:0]    tx_ctrl_reg;
  logic [7:0]    rx_ctrl_reg;
  // Flag double buffers.
  apf_flags_type in_latch_reg;
  apf_flags_type in_flag_reg;
  apf_flags_type out_drv_reg;
  // Bus handshake state.
  logic          wr_take;
  logic          rd_take;
  logic [31:0]   rd_next;
  logic          rd_hit;
  logic          wr_hit;

  // Merge the write strobes into a register image.
  function automatic logic [31:0] apf_merge(input logic [31:0] old,
                                            input logic [31:0] wd,
                                            input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction

  // Known register offsets; anything else is answered with an error.
  function automatic logic apf_mapped(input logic [7:0] a);
    return (a == APF_OFS_PIN_SELECT) || (a == APF_OFS_PIN_DIR) ||
           (a == APF_OFS_PIN_LEVEL) || (a == APF_OFS_COMMON) ||
           (a == APF_OFS_STATUS) || (a == APF_OFS_TX_CTRL) ||
           (a == APF_OFS_RX_CTRL);
  endfunction

  // Port-wide reset, shared timing and flag pin enables.
  logic port_idle;
  logic shared_timing;
  logic flag_on_bck;
  logic flag_on_fs;
  logic flag_on_fck;
  logic rx_fs_eff;
  assign port_idle = (pin_sel_reg == APF_RST_PINS) &&
                     (pin_dir_reg == APF_RST_PINS);
  assign shared_timing = common_reg[APF_CMN_SHARED];
  assign flag_on_bck = shared_timing;
  assign flag_on_fs  = shared_timing &&
                       !common_reg[APF_CMN_TXBUF_SEL];
  assign flag_on_fck = shared_timing;
  // With shared timing the receiver follows the transmit frame sync.
  assign rx_fs_eff = shared_timing ? tx_frame_sync : rx_frame_sync;

  // Pad view as seen by this port after the swap.
  logic [11:0] my_in;
  assign my_in = (pin_swap & sib_pad_in) | (~pin_swap & pad_in);

  // The write is taken once both address and data are offered.
  assign wr_take = s_axi_awvalid && s_axi_wvalid && s_axi_awready &&
                   s_axi_wready;
  assign rd_take = s_axi_arvalid && s_axi_arready;
  assign wr_hit  = apf_mapped(s_axi_awaddr);
  assign rd_hit  = apf_mapped(s_axi_araddr);

  // Write channel handshake: ready for one cycle, then the response.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= APF_RESP_OKAY;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                       !s_axi_bvalid;
      s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                       !s_axi_bvalid;
      if (wr_take) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? APF_RESP_OKAY : APF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Pin select and direction; both resets clear them.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sel_reg <= APF_RST_PINS;
      pin_dir_reg <= APF_RST_PINS;
    end else if (soft_rst) begin
      pin_sel_reg <= APF_RST_PINS;
      pin_dir_reg <= APF_RST_PINS;
    end else if (wr_take && s_axi_awaddr == APF_OFS_PIN_SELECT) begin
      pin_sel_reg <= 12'(apf_merge({20'h0, pin_sel_reg}, s_axi_wdata,
                                   s_axi_wstrb));
    end else if (wr_take && s_axi_awaddr == APF_OFS_PIN_DIR) begin
      pin_dir_reg <= 12'(apf_merge({20'h0, pin_dir_reg}, s_axi_wdata,
                                   s_axi_wstrb));
    end
  end

  // Pin data is kept through a software reset so disconnected bits stay
  // untouched; only the power-on reset gives them a known start.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_lvl_reg <= APF_RST_PINS;
    end else if (wr_take && s_axi_awaddr == APF_OFS_PIN_LEVEL) begin
      pin_lvl_reg <= 12'(apf_merge({20'h0, pin_lvl_reg}, s_axi_wdata,
                                   s_axi_wstrb));
    end
  end

  // Common, transmit and receive control registers.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      common_reg  <= APF_RST_CTRL;
      tx_ctrl_reg <= APF_RST_CTRL;
      rx_ctrl_reg <= APF_RST_CTRL;
    end else if (wr_take) begin
      if (s_axi_awaddr == APF_OFS_COMMON) begin
        common_reg <= 8'(apf_merge({24'h0, common_reg}, s_axi_wdata,
                                   s_axi_wstrb));
      end else if (s_axi_awaddr == APF_OFS_TX_CTRL) begin
        tx_ctrl_reg <= 8'(apf_merge({24'h0, tx_ctrl_reg}, s_axi_wdata,
                                    s_axi_wstrb));
      end else if (s_axi_awaddr == APF_OFS_RX_CTRL) begin
        rx_ctrl_reg <= 8'(apf_merge({24'h0, rx_ctrl_reg}, s_axi_wdata,
                                    s_axi_wstrb));
      end
    end
  end

  // Read data mux; input pins return the live pad level.
  always_comb begin
    rd_next = 32'h0;
    if (s_axi_araddr == APF_OFS_PIN_SELECT) begin
      rd_next[11:0] = pin_sel_reg;
    end else if (s_axi_araddr == APF_OFS_PIN_DIR) begin
      rd_next[11:0] = pin_dir_reg;
    end else if (s_axi_araddr == APF_OFS_PIN_LEVEL) begin
      rd_next[11:0] = (~pin_dir_reg & pin_sel_reg & my_in) |
                      ~(~pin_dir_reg & pin_sel_reg) & pin_lvl_reg;
    end else if (s_axi_araddr == APF_OFS_COMMON) begin
      rd_next[7:0] = common_reg;
    end else if (s_axi_araddr == APF_OFS_STATUS) begin
      rd_next[APF_STS_IFLAG_LSB +: 3] = in_flag_reg;
      rd_next[APF_STS_TX_EMPTY] = tx_empty_flag;
      rd_next[APF_STS_TX_RST]   = tx_rst;
      rd_next[APF_STS_RX_RST]   = rx_rst;
      rd_next[APF_STS_RX_LIVE]  = rx_capture_en;
      rd_next[APF_STS_CLK_RUN]  = clkgen_run;
    end else if (s_axi_araddr == APF_OFS_TX_CTRL) begin
      rd_next[7:0] = tx_ctrl_reg;
    end else if (s_axi_araddr == APF_OFS_RX_CTRL) begin
      rd_next[7:0] = rx_ctrl_reg;
    end
  end

  // Read channel handshake: one cycle of ready, data on the next edge.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= APF_RESP_OKAY;
    end else begin
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      if (rd_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_next;
        s_axi_rresp  <= rd_hit ? APF_RESP_OKAY : APF_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Section resets, clock run and interrupt permission.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_rst     <= 1'b1;
      rx_rst     <= 1'b1;
      clkgen_run <= 1'b0;
      irq_allow  <= 1'b0;
    end else begin
      tx_rst     <= port_idle || tx_ctrl_reg[APF_TXC_RESET];
      rx_rst     <= port_idle || rx_ctrl_reg[APF_RXC_RESET];
      clkgen_run <= !port_idle;
      irq_allow  <= !port_idle;
    end
  end

  // Receiver arms on the first frame sync after a channel is enabled.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_capture_en <= 1'b0;
    end else begin
      if (rx_rst || rx_ctrl_reg[APF_RXC_ON_LSB +: APF_RX_CH] == 4'h0) begin
        rx_capture_en <= 1'b0;
      end else if (rx_fs_eff) begin
        rx_capture_en <= 1'b1;
      end
    end
  end

  // Each transmitter stays tri-stated until a frame sync follows its enable.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_drive_en <= 6'h00;
    end else begin
      for (int k = 0; k < APF_TX_CH; k++) begin
        if (tx_rst || !tx_ctrl_reg[APF_TXC_ON_LSB + k]) begin
          tx_drive_en[k] <= 1'b0;
        end else if (tx_frame_sync) begin
          tx_drive_en[k] <= 1'b1;
        end
      end
    end
  end

  // Input flags: latch on the first received bit, publish on word landing.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      in_latch_reg <= '0;
      in_flag_reg  <= '0;
    end else if (rx_rst) begin
      in_latch_reg <= '0;
      in_flag_reg  <= '0;
    end else begin
      if (rx_first_bit) begin
        in_latch_reg.bitclk <= my_in[APF_PIN_BITCLK];
        in_latch_reg.fsync  <= my_in[APF_PIN_FSYNC];
        in_latch_reg.fast   <= my_in[APF_PIN_FAST];
      end
      if (rx_word_done) begin
        in_flag_reg <= in_latch_reg;
      end
    end
  end

  // Output flags follow the control bits only when transmit data loads,
  // so software may rewrite them for the next word without a glitch.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_drv_reg <= '0;
    end else if (tx_rst) begin
      out_drv_reg <= '0;
    end else if (tx_word_load) begin
      out_drv_reg <= common_reg[APF_CMN_OFLAG_LSB +: 3];
    end
  end

  // Per-pin function selection ahead of the swap.
  apf_drive_type my_drive;
  logic [2:0]    flag_on;
  logic [2:0]    flag_dir;
  logic [2:0]    flag_out;
  always_comb begin
    flag_on  = {flag_on_fck, flag_on_fs, flag_on_bck};
    flag_dir = {rx_ctrl_reg[APF_RXC_FCK_DIR],
                rx_ctrl_reg[APF_RXC_FS_DIR],
                rx_ctrl_reg[APF_RXC_BCK_DIR]};
    flag_out = out_drv_reg;
    my_drive = '0;
    for (int i = 0; i < APF_PINS; i++) begin
      case ({pin_dir_reg[i], pin_sel_reg[i]})
        2'b10: begin
          my_drive.oe[i]    = 1'b1;
          my_drive.level[i] = pin_lvl_reg[i];
        end
        2'b11: begin
          if (i < 3 && flag_on[i]) begin
            my_drive.oe[i]    = flag_dir[i];
            my_drive.level[i] = flag_out[i];
          end else begin
            my_drive.oe[i]    = ser_drive.oe[i];
            my_drive.level[i] = ser_drive.level[i];
          end
        end
        default: begin
          my_drive.oe[i]    = 1'b0;
          my_drive.level[i] = 1'b0;
        end
      endcase
    end
  end

  // Pad routing with the sibling; one flop keeps every output registered.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pad_drive     <= '0;
      sib_pad_drive <= '0;
      sib_in_level  <= 12'h000;
      ser_in_level  <= 12'h000;
    end else begin
      pad_drive.oe     <= (pin_swap & sib_drive.oe) |
                          (~pin_swap & my_drive.oe);
      pad_drive.level  <= (pin_swap & sib_drive.level) |
                          (~pin_swap & my_drive.level);
      sib_pad_drive.oe    <= pin_swap & my_drive.oe;
      sib_pad_drive.level <= pin_swap & my_drive.level;
      sib_in_level <= pin_swap & pad_in;
      ser_in_level <= my_in & pin_sel_reg & pin_dir_reg;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  chk_idle_holds_resets: assert property (
    port_idle |=> (tx_rst && rx_rst && !clkgen_run))
    else $error("Idle port did not hold both sections in reset.");
  chk_tx_reset_only: assert property (
    (!port_idle && tx_ctrl_reg[APF_TXC_RESET] &&
     !rx_ctrl_reg[APF_RXC_RESET]) |=> (tx_rst && !rx_rst))
    else $error("Transmit reset disturbed the receiver.");
  chk_soft_clears_pins: assert property (
    soft_rst |=> (pin_sel_reg == 12'h000 && pin_dir_reg == 12'h000))
    else $error("Software reset left pin setup set.");
  chk_rx_waits_sync: assert property (
    (!rx_capture_en && !rx_fs_eff) |=> !rx_capture_en)
    else $error("Receiver started without a frame sync.");
  chk_tx_tristate: assert property (
    $rose(tx_drive_en[0]) |-> $past(tx_frame_sync) && !tx_rst)
    else $error("Transmitter drove before a frame sync.");
  chk_in_flag_hold: assert property (
    (!rx_first_bit && !rx_rst) |=> $stable(in_latch_reg))
    else $error("Input flag latch moved between first bits.");
  chk_in_flag_post: assert property (
    (rx_word_done && !rx_rst) |=> in_flag_reg == $past(in_latch_reg))
    else $error("Status flags missed the latched values.");
  chk_out_flag_load: assert property (
    (!tx_word_load && !tx_rst) |=> $stable(out_drv_reg))
    else $error("Output flags changed without a word load.");
  chk_gpio_out_pad: assert property (
    (pin_dir_reg[5] && !pin_sel_reg[5] && !pin_swap[5]) |=>
      (pad_drive.oe[5] && pad_drive.level[5] == $past(pin_lvl_reg[5])))
    else $error("General output pin not driven from its data bit.");
  chk_swap_route: assert property (
    pin_swap[7] |=> (pad_drive.oe[7] == $past(sib_drive.oe[7]) &&
                     sib_pad_drive.oe[7] == $past(my_drive.oe[7])))
    else $error("Swapped pin not routed to the sibling.");
  chk_flag_async_off: assert property (
    (!shared_timing && pin_sel_reg[0] && pin_dir_reg[0] && !pin_swap[0])
      |=> pad_drive.oe[0] == $past(ser_drive.oe[0]))
    else $error("Flag logic took the pin outside shared timing.");
  chk_no_irq_idle: assert property (
    port_idle |=> !irq_allow)
    else $error("Interrupts allowed while port held in reset.");

endmodule

// File: src/apf_pkg.sv
package apf_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] APF_OFS_PIN_SELECT = 8'h00;
  localparam logic [7:0] APF_OFS_PIN_DIR    = 8'h04;
  localparam logic [7:0] APF_OFS_PIN_LEVEL  = 8'h08;
  localparam logic [7:0] APF_OFS_COMMON     = 8'h0c;
  localparam logic [7:0] APF_OFS_STATUS     = 8'h10;
  localparam logic [7:0] APF_OFS_TX_CTRL    = 8'h14;
  localparam logic [7:0] APF_OFS_RX_CTRL    = 8'h18;

  // Widths of the port and of the section enables.
  localparam int APF_PINS  = 12;
  localparam int APF_TX_CH = 6;
  localparam int APF_RX_CH = 4;

  // Pin positions of the three serial flags.
  localparam int APF_PIN_BITCLK = 0;
  localparam int APF_PIN_FSYNC  = 1;
  localparam int APF_PIN_FAST   = 2;

  // Field positions in the common control register.
  localparam int APF_CMN_OFLAG_LSB = 0;
  localparam int APF_CMN_SHARED    = 3;
  localparam int APF_CMN_TXBUF_SEL = 4;

  // Field positions in the transmit control register.
  localparam int APF_TXC_ON_LSB = 0;
  localparam int APF_TXC_RESET  = 6;

  // Field positions in the receive control register.
  localparam int APF_RXC_ON_LSB  = 0;
  localparam int APF_RXC_RESET   = 4;
  localparam int APF_RXC_BCK_DIR = 5;
  localparam int APF_RXC_FS_DIR  = 6;
  localparam int APF_RXC_FCK_DIR = 7;

  // Field positions in the status register.
  localparam int APF_STS_IFLAG_LSB = 0;
  localparam int APF_STS_TX_EMPTY  = 3;
  localparam int APF_STS_TX_RST    = 4;
  localparam int APF_STS_RX_RST    = 5;
  localparam int APF_STS_RX_LIVE   = 6;
  localparam int APF_STS_CLK_RUN   = 7;

  // Values after reset.
  localparam logic [11:0] APF_RST_PINS = 12'h000;
  localparam logic [7:0]  APF_RST_CTRL = 8'h00;

  // AXI responses.
  localparam logic [1:0] APF_RESP_OKAY   = 2'h0;
  localparam logic [1:0] APF_RESP_SLVERR = 2'h2;

  // The three serial flags, one bit per flag pin.
  typedef struct packed {
    logic fast;
    logic fsync;
    logic bitclk;
  } apf_flags_type;

  // One port's worth of drive: level and enable, per pin.
  typedef struct packed {
    logic [11:0] level;
    logic [11:0] oe;
  } apf_drive_type;

endpackage

// File: tb/apf_pin_model.sv
module apf_pin_model
  import apf_pkg::*;
(
  // Port drive and far-side levels.
  input  wire apf_pkg::apf_drive_type drv,
  input  wire logic [11:0]            far,
  // Resolved pad levels.
  output logic [11:0]                 lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  // A pin that the port drives shows its level, else the codec side wins.
  always_comb begin
    for (int i = 0; i < 12; i++) begin
      lvl[i] = drv.oe[i] ? drv.level[i] : far[i];
    end
  end
endmodule

// File: tb/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import apf_pkg::*;
  logic          clk, arst_n, soft_rst, s_axi_awvalid, s_axi_wvalid;
  logic          s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awready;
  logic          s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]    s_axi_awaddr, s_axi_araddr;
  logic [31:0]   s_axi_wdata, s_axi_rdata, rdv, sel, dir, dat, ex;
  logic [3:0]    s_axi_wstrb;
  logic [1:0]    s_axi_bresp, s_axi_rresp, rsp;
  logic          rx_first_bit, rx_word_done, tx_word_load, tx_frame_sync;
  logic          rx_frame_sync, tx_empty_flag, tx_rst, rx_rst, clkgen_run;
  logic          rx_capture_en, irq_allow;
  logic [5:0]    tx_drive_en;
  logic [11:0]   ser_in_level, pad_in, pin_swap, sib_pad_in, sib_in_level;
  logic [11:0]   far;
  apf_drive_type ser_drive, pad_drive, sib_drive, sib_pad_drive;
  int            fail_count, n_checks, seed, i;

  apf_gpio u_dut (.clk, .arst_n, .soft_rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rx_first_bit, .rx_word_done, .tx_word_load, .tx_frame_sync,
    .rx_frame_sync, .tx_empty_flag, .ser_drive, .tx_rst, .rx_rst, .clkgen_run,
    .rx_capture_en, .tx_drive_en, .irq_allow, .ser_in_level, .pad_in,
    .pad_drive, .pin_swap, .sib_pad_in, .sib_drive, .sib_pad_drive,
    .sib_in_level);
  apf_pin_model u_pins (.drv(pad_drive), .far(far), .lvl(pad_in));

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Case equality keeps an unknown from passing as a match.
  task automatic check(input logic [31:0] got, input logic [31:0] e);
    n_checks++;
    if (got !== e) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, e);
    end
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Each channel is held until its own ready; the slave sets the pace.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic pa, pw;
    @(posedge clk);
    pa = 1'b1;
    pw = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw) begin
      @(posedge clk);
      if (s_axi_awready) pa = 1'b0;
      if (s_axi_wready) pw = 1'b0;
      if (!pa) s_axi_awvalid <= 1'b0;
      if (!pw) s_axi_wvalid <= 1'b0;
    end
    while (!s_axi_bvalid) @(posedge clk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // One-cycle event strobe by index: 0 first bit, 1 word done, 2 load,
  // 3 transmit sync, 4 receive sync.
  task automatic pulse(input int w);
    rx_first_bit <= (w == 0);
    rx_word_done <= (w == 1);
    tx_word_load <= (w == 2);
    tx_frame_sync <= (w == 3);
    rx_frame_sync <= (w == 4);
    @(posedge clk);
    {rx_first_bit, rx_word_done, tx_word_load} <= 3'h0;
    {tx_frame_sync, rx_frame_sync} <= 2'h0;
    @(posedge clk);
  endtask

  // A hang costs a mismatch and ends the run in the usual place.
  initial begin
    #100000;
    fail_count++;
    end_sim();
  end

  // Main sequence: reset, pin functions, flags, sections, swap.
  initial begin
    seed = 32'h747bd962;
    {arst_n, soft_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, rx_first_bit, rx_word_done} = '0;
    {tx_word_load, tx_frame_sync, rx_frame_sync} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {ser_drive, sib_drive, pin_swap, far} = '0;
    s_axi_wstrb = 4'hf;
    tx_empty_flag = 1'b1;
    sib_pad_in = 12'ha5c;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    axi_rd(APF_OFS_STATUS, rdv, rsp);
    check(rdv, 32'h38);
    check(irq_allow, 1'b0);
    for (i = 0; i < 3; i++) begin
      sel = $random(seed) & 32'hfff;
      dir = $random(seed) & 32'hfff;
      dat = $random(seed) & 32'hfff;
      far <= 12'($random(seed));
      ser_drive <= 24'($random(seed));
      axi_wr(APF_OFS_PIN_SELECT, sel, rsp);
      axi_wr(APF_OFS_PIN_DIR, dir, rsp);
      axi_wr(APF_OFS_PIN_LEVEL, dat, rsp);
      repeat (3) @(posedge clk);
      check(pad_drive.oe, (dir & ~sel) | (dir & sel & ser_drive.oe));
      check(pad_drive.level & dir & ~sel, dat & dir & ~sel);
      check(tx_rst, (sel | dir) == 0);
      check(clkgen_run, (sel | dir) != 0);
      check(irq_allow, (sel | dir) != 0);
      axi_rd(APF_OFS_PIN_LEVEL, rdv, rsp);
      ex = (far & sel & ~dir) | (dat & ~(sel & ~dir));
      check(rdv, ex & 32'hfff);
    end
    soft_rst <= 1'b1;
    @(posedge clk);
    soft_rst <= 1'b0;
    axi_rd(APF_OFS_PIN_SELECT, rdv, rsp);
    check(rdv, 32'h0);
    axi_rd(APF_OFS_PIN_DIR, rdv, rsp);
    check(rdv, 32'h0);
    axi_rd(APF_OFS_PIN_LEVEL, rdv, rsp);
    check(rdv, dat);
    axi_wr(APF_OFS_PIN_SELECT, 32'h7, rsp);
    axi_wr(APF_OFS_PIN_DIR, 32'h7, rsp);
    axi_wr(APF_OFS_RX_CTRL, 32'he0, rsp);
    axi_wr(APF_OFS_COMMON, 32'hd, rsp);
    pulse(2);
    @(posedge clk);
    check(pad_drive.oe[2:0], 3'b111);
    check(pad_drive.level[2:0], 3'b101);
    axi_wr(APF_OFS_COMMON, 32'ha, rsp);
    repeat (2) @(posedge clk);
    check(pad_drive.level[2:0], 3'b101);
    pulse(2);
    @(posedge clk);
    check(pad_drive.level[2:0], 3'b010);
    // Buffer-enable use of the frame sync pin hands it back to the core.
    ser_drive <= '0;
    axi_wr(APF_OFS_COMMON, 32'h1a, rsp);
    repeat (2) @(posedge clk);
    check(pad_drive.oe[1:0], 2'b01);
    axi_wr(APF_OFS_RX_CTRL, 32'h0, rsp);
    far <= 12'h6;
    @(posedge clk);
    pulse(0);
    far <= 12'h1;
    pulse(1);
    check(pad_drive.oe[2:0], 3'b000);
    axi_rd(APF_OFS_STATUS, rdv, rsp);
    check(rdv[2:0], 3'b110);
    axi_wr(APF_OFS_TX_CTRL, 32'h1, rsp);
    axi_wr(APF_OFS_RX_CTRL, 32'h1, rsp);
    repeat (2) @(posedge clk);
    check({tx_drive_en[0], rx_capture_en}, 2'b00);
    pulse(3);
    @(posedge clk);
    check({tx_drive_en[0], rx_capture_en}, 2'b11);
    // Without shared timing only the receive frame sync arms the receiver.
    axi_wr(APF_OFS_RX_CTRL, 32'h0, rsp);
    axi_wr(APF_OFS_COMMON, 32'h0, rsp);
    axi_wr(APF_OFS_RX_CTRL, 32'h1, rsp);
    pulse(3);
    @(posedge clk);
    check(rx_capture_en, 1'b0);
    pulse(4);
    @(posedge clk);
    check(rx_capture_en, 1'b1);
    axi_wr(APF_OFS_TX_CTRL, 32'h40, rsp);
    axi_rd(APF_OFS_STATUS, rdv, rsp);
    check(rdv[5:4], 2'b01);
    axi_rd(8'h1c, rdv, rsp);
    check(rdv, 32'h0);
    check(rsp, APF_RESP_SLVERR);
    axi_wr(8'h1c, 32'hffff, rsp);
    check(rsp, APF_RESP_SLVERR);
    sib_drive <= 24'($random(seed));
    ser_drive <= 24'($random(seed));
    pin_swap <= 12'hfff;
    repeat (3) @(posedge clk);
    check(pad_drive, sib_drive);
    check(sib_pad_drive, ser_drive & 24'h007007);
    check(sib_in_level, pad_in);
    check(ser_in_level, sib_pad_in & 12'h007);
    end_sim();
  end
endmodule
